//--- src/serial_eeprom_bus_addressing.sv
// Two-wire EEPROM slave: addressing, acknowledge, read/write, program lockout
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_bus_addressing #(
  parameter logic [3:0]  DEV_TYPE    = 4'h5,  // Arbitrary value, set per system
  parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_CYCLES_STD  // Program time
) (
  // System clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Two-wire link
  input  wire logic scl_clk,
  input  wire logic sda_in,
  output var  logic sda_out,
  output var  logic sda_oe,
  // Write-protect strap
  input  wire logic wp
);

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  link_if lk ();  // Sampled link levels
  mem_if  m  ();  // Array port

  link_sampler u_sampler (
    .clk_sys (clk_sys),
    .scl_clk (scl_clk),
    .arst_n  (arst_n),
    .sda_in  (sda_in),
    .wp      (wp),
    .lk      (lk)
  );

  eeprom_array u_array (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .m       (m)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  eeprom_pkg::st_t            state_reg, state_next;  // Protocol state
  eeprom_pkg::st_t            ret_reg, ret_next;      // State after the ninth clock
  logic [3:0]                 cnt_reg, cnt_next;      // Bits seen in this byte
  logic [7:0]                 shift_reg, shift_next;  // Byte in or out
  logic                       oe_reg, oe_next;        // Pulling the data line low
  logic [2:0]                 blk_reg, blk_next;      // Page block
  logic [7:0]                 word_reg, word_next;    // Array address
  logic                       wrote_reg, wrote_next;  // Bytes stored since the last stop
  logic [eeprom_pkg::TMR_W-1:0] tmr_reg, tmr_next;    // Program time counter
  logic                       we_next;                // Array write this cycle
  logic                       tog_d_reg;              // Last toggle level
  logic                       scl_d_reg;              // Last clock level
  logic                       sda_d_reg;              // Last data level
  logic                       out_reg;                // Open-drain level, always low

  // ----------------------------------------------------------------
  // Event and field decoding
  // ----------------------------------------------------------------
  wire rise_ev  = lk.tog_lvl ^ tog_d_reg;              // Clock line rose
  wire fall_ev  = scl_d_reg & ~lk.scl_lvl;             // Clock line fell
  wire scl_hi   = scl_d_reg & lk.scl_lvl;              // Clock steady high
  wire start_ev = scl_hi & sda_d_reg & ~lk.sda_lvl;    // Data fell, clock high
  wire stop_ev  = scl_hi & ~sda_d_reg & lk.sda_lvl;    // Data rose, clock high
  wire byte_end = fall_ev & (cnt_reg == eeprom_pkg::BYTE_BITS);
  // Only the device type is compared; all select bits pick blocks
  wire type_hit = shift_reg[eeprom_pkg::TYPE_MSB:eeprom_pkg::TYPE_LSB] == DEV_TYPE;
  wire dir_rd   = shift_reg[eeprom_pkg::DIR_BIT];      // One reads, zero writes
  // Upper half is the top block bit of the internal address
  wire prot_hit = lk.wp_lvl & blk_reg[eeprom_pkg::UPPER_BIT];
  wire tmr_last = tmr_reg == eeprom_pkg::TMR_W'(PROG_CYCLES - 1);
  wire [3:0] cnt_inc = 4'(cnt_reg + 4'h1);
  wire [3:0] page_inc = 4'(word_reg[3:0] + 4'h1);       // Wraps inside the page
  wire [10:0] seq_inc = 11'({blk_reg, word_reg} + 11'h001);

  // Block over array address forms the byte address
  assign m.addr    = {blk_reg, word_reg};
  assign m.wr_data = shift_reg;
  assign m.we      = we_next;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    ret_next   = ret_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    oe_next    = oe_reg;
    blk_next   = blk_reg;
    word_next  = word_reg;
    wrote_next = wrote_reg;
    tmr_next   = tmr_reg;
    we_next    = 1'b0;
    if (state_reg == eeprom_pkg::ST_PROGRAM) begin
      // Bus is ignored entirely; line left to the pull-up
      oe_next  = 1'b0;
      tmr_next = eeprom_pkg::TMR_W'(tmr_reg + 1'b1);
      if (tmr_last) begin
        state_next = eeprom_pkg::ST_IDLE;
      end
    end else if (start_ev) begin
      // Start or repeated start reopens addressing outside the program cycle
      state_next = eeprom_pkg::ST_ADDR;
      cnt_next   = eeprom_pkg::BIT_CNT_RST;
      oe_next    = 1'b0;
    end else if (stop_ev) begin
      // A stop after stored bytes launches the program cycle
      oe_next    = 1'b0;
      wrote_next = 1'b0;
      tmr_next   = '0;
      state_next = wrote_reg ? eeprom_pkg::ST_PROGRAM : eeprom_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        eeprom_pkg::ST_ADDR, eeprom_pkg::ST_WORD, eeprom_pkg::ST_DATA: begin
          if (rise_ev) begin
            // Most significant bit first
            shift_next = {shift_reg[6:0], lk.rise_bit};
            cnt_next   = cnt_inc;
          end else if (byte_end) begin
            state_next = eeprom_pkg::ST_ACK;
            oe_next    = 1'b1;  // Low through the ninth clock
            if (state_reg == eeprom_pkg::ST_ADDR) begin
              blk_next = shift_reg[eeprom_pkg::SEL_MSB:eeprom_pkg::SEL_LSB];
              // Reads hand the transmitter role to the device
              ret_next = dir_rd ? eeprom_pkg::ST_TX : eeprom_pkg::ST_WORD;
              if (!type_hit) begin
                state_next = eeprom_pkg::ST_IDLE;  // Not us: stay silent
                oe_next    = 1'b0;
                blk_next   = blk_reg;
              end
            end else if (state_reg == eeprom_pkg::ST_WORD) begin
              word_next = shift_reg;  // Array address byte
              ret_next  = eeprom_pkg::ST_DATA;
            end else if (prot_hit) begin
              // Protected data byte: no store, no acknowledge
              state_next = eeprom_pkg::ST_WAIT;
              oe_next    = 1'b0;
            end else begin
              we_next    = 1'b1;
              wrote_next = 1'b1;
              word_next  = {word_reg[7:4], page_inc};
              ret_next   = eeprom_pkg::ST_DATA;
            end
          end
        end
        eeprom_pkg::ST_ACK: begin
          if (fall_ev) begin
            // Release after the ninth clock, or put out a read byte
            state_next = ret_reg;
            cnt_next   = eeprom_pkg::BIT_CNT_RST;
            shift_next = m.rd_data;
            oe_next    = (ret_reg == eeprom_pkg::ST_TX) ? ~m.rd_data[7] : 1'b0;
          end
        end
        eeprom_pkg::ST_TX: begin
          if (rise_ev) begin
            cnt_next = cnt_inc;
          end else if (byte_end) begin
            // Eight bits out: let go and listen
            state_next = eeprom_pkg::ST_TX_ACK;
            oe_next    = 1'b0;
          end else if (fall_ev) begin
            shift_next = {shift_reg[6:0], 1'b0};
            oe_next    = ~shift_reg[6];
          end
        end
        eeprom_pkg::ST_TX_ACK: begin
          if (rise_ev) begin
            if (!lk.rise_bit) begin
              // Master kept the transfer alive: next byte
              {blk_next, word_next} = seq_inc;
              state_next = eeprom_pkg::ST_ACK;
              ret_next   = eeprom_pkg::ST_TX;
            end else begin
              state_next = eeprom_pkg::ST_WAIT;
            end
          end
        end
        eeprom_pkg::ST_IDLE, eeprom_pkg::ST_WAIT: begin
          oe_next = 1'b0;  // Only start or stop leaves these
        end
        default: begin
          state_next = eeprom_pkg::ST_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Protocol registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= eeprom_pkg::ST_IDLE;
      ret_reg   <= eeprom_pkg::ST_IDLE;
      cnt_reg   <= eeprom_pkg::BIT_CNT_RST;
      shift_reg <= 8'h00;
      oe_reg    <= 1'b0;
      wrote_reg <= 1'b0;
      tmr_reg   <= '0;
    end else begin
      state_reg <= state_next;
      ret_reg   <= ret_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      oe_reg    <= oe_next;
      wrote_reg <= wrote_next;
      tmr_reg   <= tmr_next;
    end
  end

  // Address registers; they persist so a bare read starts after the last byte written, or at the last byte read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      blk_reg  <= 3'h0;
      word_reg <= 8'h00;
    end else begin
      blk_reg  <= blk_next;
      word_reg <= word_next;
    end
  end

  // Edge history of the synchronised levels
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tog_d_reg <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      out_reg   <= 1'b0;
    end else begin
      tog_d_reg <= lk.tog_lvl;
      scl_d_reg <= lk.scl_lvl;
      sda_d_reg <= lk.sda_lvl;
      out_reg   <= 1'b0;
    end
  end

  assign sda_out = out_reg;
  assign sda_oe  = oe_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_end(eeprom_pkg::st_t st);
    byte_end && state_reg == st && !start_ev && !stop_ev;
  endsequence

  a_prog_quiet: assert property (state_reg == eeprom_pkg::ST_PROGRAM |-> !oe_reg)
    else $error("data line driven during program cycle");
  a_prog_deaf: assert property (state_reg == eeprom_pkg::ST_PROGRAM && !tmr_last
    |=> state_reg == eeprom_pkg::ST_PROGRAM && !oe_reg)
    else $error("program cycle left early");
  a_prog_end: assert property (state_reg == eeprom_pkg::ST_PROGRAM && tmr_last
    |=> state_reg == eeprom_pkg::ST_IDLE)
    else $error("program cycle overran its time");
  a_type_miss: assert property (s_end(eeprom_pkg::ST_ADDR) and !type_hit
    |=> state_reg == eeprom_pkg::ST_IDLE ##1 !oe_reg)
    else $error("answered a foreign device type");
  a_dir_decode: assert property (s_end(eeprom_pkg::ST_ADDR) and type_hit
    |=> ret_reg == ($past(dir_rd) ? eeprom_pkg::ST_TX : eeprom_pkg::ST_WORD))
    else $error("direction bit decoded wrongly");
  a_ack_hold: assert property (state_reg == eeprom_pkg::ST_ACK && oe_reg && !fall_ev
    && !start_ev && !stop_ev |=> oe_reg)
    else $error("acknowledge released inside ninth clock");
  a_word_take: assert property (s_end(eeprom_pkg::ST_WORD)
    |=> oe_reg && m.addr == {blk_reg, $past(shift_reg)})
    else $error("array address not taken");
  a_wp_refuse: assert property (s_end(eeprom_pkg::ST_DATA) and prot_hit
    |-> !we_next ##1 !oe_reg)
    else $error("protected byte stored or acknowledged");
  a_page_wrap: assert property (we_next |=> word_reg[7:4] == $past(word_reg[7:4]))
    else $error("write left its page");
  a_nack_wait: assert property (state_reg == eeprom_pkg::ST_TX_ACK && rise_ev
    && lk.rise_bit && !start_ev && !stop_ev |=> state_reg == eeprom_pkg::ST_WAIT [*2])
    else $error("kept sending after no acknowledge");

endmodule // serial_eeprom_bus_addressing

`default_nettype wire

//--- src/eeprom_pkg.sv
// Shared constants and types of the two-wire EEPROM front end
package eeprom_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int unsigned BLK_W    = 3;                // Page-block select width
  localparam int unsigned WORD_W   = 8;                // Array address width
  localparam int unsigned MEM_AW   = BLK_W + WORD_W;   // Internal byte address width
  localparam int unsigned MEM_DEPTH = 2048;            // Bytes in the array
  localparam int unsigned TYPE_MSB = 7;                // Device type field top bit
  localparam int unsigned TYPE_LSB = 4;                // Device type field low bit
  localparam int unsigned SEL_MSB  = 3;                // Select field top bit
  localparam int unsigned SEL_LSB  = 1;                // Select field low bit
  localparam int unsigned DIR_BIT  = 0;                // Direction bit position
  localparam int unsigned UPPER_BIT = BLK_W - 1;       // Block bit marking upper half

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000; // System clock rate
  localparam int unsigned PROG_TIME_STD_MS = 10;        // Program time, standard part
  localparam int unsigned PROG_TIME_LP_MS  = 15;        // Program time, low-power part
  localparam int unsigned PROG_CYCLES_STD = (CLK_HZ / 1000) * PROG_TIME_STD_MS;
  localparam int unsigned PROG_CYCLES_LP  = (CLK_HZ / 1000) * PROG_TIME_LP_MS;
  localparam int unsigned TMR_W           = 18;         // Holds either count

  // ----------------------------------------------------------------
  // Reset values and protocol state
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_CNT_RST = 4'h0;  // Bit counter after reset
  localparam logic [3:0] BYTE_BITS   = 4'h8;  // Bits in one byte

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,  // Waiting for a start
    ST_ADDR    = 4'h1,  // Shifting in the slave address byte
    ST_WORD    = 4'h2,  // Shifting in the array address byte
    ST_DATA    = 4'h3,  // Shifting in write data bytes
    ST_ACK     = 4'h4,  // Ninth clock, driven low by the device unless a read byte follows a master acknowledge
    ST_TX      = 4'h5,  // Shifting out read data
    ST_TX_ACK  = 4'h6,  // Ninth clock, master's answer sampled
    ST_WAIT    = 4'h7,  // Ignoring the bus until start or stop
    ST_PROGRAM = 4'h8   // Self-timed program cycle, bus ignored
  } st_t;

endpackage

//--- src/eeprom_ifs.sv
// Internal carriers: sampled link levels and array port
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Sampled link levels, all but rise_bit already in the system clock domain
// ------------------------------------------------------------------
interface link_if;
  logic scl_lvl;   // Clock line level
  logic sda_lvl;   // Data line level
  logic wp_lvl;    // Write-protect strap level
  logic tog_lvl;   // Toggles once per clock-line rising edge
  logic rise_bit;  // Data bit caught at the last rising edge
  modport sampler (output scl_lvl, sda_lvl, wp_lvl, tog_lvl, rise_bit);
  modport engine  (input  scl_lvl, sda_lvl, wp_lvl, tog_lvl, rise_bit);
endinterface

// ------------------------------------------------------------------
// Byte array port
// ------------------------------------------------------------------
interface mem_if;
  logic        we;       // Write strobe, one cycle
  logic [10:0] addr;     // Byte address for read and write
  logic [7:0]  wr_data;  // Byte to store
  logic [7:0]  rd_data;  // Registered read of addr
  modport array  (input we, addr, wr_data, output rd_data);
  modport engine (output we, addr, wr_data, input rd_data);
endinterface

`default_nettype wire

//--- src/eeprom_array.sv
// Byte array of the EEPROM with registered read
`timescale 1ns/1ps
`default_nettype none

module eeprom_array (
  // System clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Array port
  mem_if.array      m
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] cell_mem [eeprom_pkg::MEM_DEPTH];  // Non-volatile cells, no reset
  logic [7:0] rd_reg;                            // Read data register

  // Write port; cells keep their content across reset like the real array
  always_ff @(posedge clk_sys) begin
    if (m.we) begin
      cell_mem[m.addr] <= m.wr_data;
    end
  end

  // Read every cycle so the engine never waits on a read strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_reg <= 8'h00;
    end else begin
      rd_reg <= cell_mem[m.addr];
    end
  end

  assign m.rd_data = rd_reg;

endmodule // eeprom_array

`default_nettype wire

//--- src/link_sampler.sv
// Link-clock bit capture and synchronisers into the system domain
`timescale 1ns/1ps
`default_nettype none

module link_sampler (
  // Clocks and reset
  input  wire logic clk_sys,
  input  wire logic scl_clk,
  input  wire logic arst_n,
  // Pins
  input  wire logic sda_in,
  input  wire logic wp,
  // Sampled levels
  link_if.sampler   lk
);

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  logic bit_reg;  // Data level at the last clock-line rise
  logic tog_reg;  // Flips on every clock-line rise

  // The bit stays put for a whole clock-line period, far longer than
  // the toggle needs to cross, so the system side reads it safely
  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_reg <= 1'b1;
      tog_reg <= 1'b0;
    end else begin
      bit_reg <= sda_in;
      tog_reg <= ~tog_reg;
    end
  end

  // ----------------------------------------------------------------
  // Two-stage synchronisers, one per crossing level
  // ----------------------------------------------------------------
  logic [3:0] raw_lvl;   // Levels before crossing
  logic [3:0] meta_reg;  // First stage, read only by the second
  logic [3:0] sync_reg;  // Second stage, safe to use

  assign raw_lvl = {tog_reg, wp, sda_in, scl_clk};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      // Idle bus is high, so the line stages reset high
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          meta_reg[gi] <= (gi < 2) ? 1'b1 : 1'b0;
          sync_reg[gi] <= (gi < 2) ? 1'b1 : 1'b0;
        end else begin
          meta_reg[gi] <= raw_lvl[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  assign lk.scl_lvl  = sync_reg[0];
  assign lk.sda_lvl  = sync_reg[1];
  assign lk.wp_lvl   = sync_reg[2];
  assign lk.tog_lvl  = sync_reg[3];
  assign lk.rise_bit = bit_reg;

endmodule // link_sampler

`default_nettype wire

//--- test/bus_master_model.sv
// Two-wire bus master model: drives the clock line and pulls the data line
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
  // Link lines
  output var  logic scl,
  output var  logic m_oe,
  input  wire logic sda
);
  // ----------------------------------------------------------------
  // Timing and results
  // ----------------------------------------------------------------
  localparam time PH = 1100;  // Clock phase, above the 1 us floor of the front end
  localparam time HP = 550;   // Data moves mid-low, clear of both clock edges
  logic [7:0] rx_val;         // Byte seen on the line
  logic       rx_ack;         // Ninth-bit level, low means acknowledged
  event       rx_evt;         // Fires once per finished byte

  // Idle bus: clock high, data released
  initial begin
    scl  = 1'b1;
    m_oe = 1'b0;
  end

  // One clock pulse, entered half a phase after the clock fell
  task automatic bit_io(input logic pull, output logic got);
    m_oe = pull;
    #HP scl = 1'b1;
    #HP got = sda;
    #HP scl = 1'b0;
    #HP;
  endtask

  // Start, also repeated: data rises while clock is low, then falls under a high clock
  task automatic start();
    m_oe = 1'b0;
    #HP scl = 1'b1;
    #PH m_oe = 1'b1;
    #PH scl = 1'b0;
    #HP;
  endtask

  // Stop: data rises while the clock is high
  task automatic stop();
    m_oe = 1'b1;
    #HP scl = 1'b1;
    #PH m_oe = 1'b0;
    #PH;
  endtask

  // Byte MSB first; line released on the ninth clock unless the master acknowledges
  task automatic byte_io(input logic [7:0] tx, input logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(~tx[i], rx_val[i]);
    end
    bit_io(ack, rx_ack);
    -> rx_evt;
  endtask
endmodule // bus_master_model

`default_nettype wire

//--- test/test_serial_eeprom_bus_addressing.sv
// Self-checking bench of the two-wire EEPROM front end
`timescale 1ns/1ps
`default_nettype none

module test_serial_eeprom_bus_addressing;
  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV = 4'h5;    // Arbitrary type code
  localparam logic [8:0] ACK = 9'h000;  // Expect acknowledge
  localparam logic [8:0] NAK = 9'h001;  // Expect released line
  logic       clk_sys, arst_n, wp;
  logic       scl, m_oe, sda_oe, sda_out, sda;
  logic [8:0] exp_q[$];                 // Bit 8 set marks a read byte
  logic [2:0] blk;
  logic [7:0] wa, d0, d1;
  int         error_cnt = 0, tests_run = 0, cyc = 0;

  // Open drain with pull-up; the device only pulls when its driven level is low
  assign sda = !((sda_oe && !sda_out) || m_oe);

  bus_master_model mm (.scl(scl), .m_oe(m_oe), .sda(sda));

  serial_eeprom_bus_addressing #(.DEV_TYPE(DEV), .PROG_CYCLES(400)) dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .scl_clk(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp));

  // 10 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Run ceiling, some eight times the expected length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      fail("timeout");
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic fail(input string m);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic chk_ack(input logic e);
    tests_run++;
    if (mm.rx_ack !== e) fail("ninth bit level");
  endtask

  task automatic chk_byte(input logic [7:0] e);
    tests_run++;
    if (mm.rx_val !== e) fail("read byte");
  endtask

  // Oldest note is matched against each finished byte
  initial begin : watch
    logic [8:0] e;
    forever begin
      @(mm.rx_evt);
      e = exp_q.pop_front();
      if (e[8]) begin
        chk_byte(e[7:0]);
        chk_ack(1'b1);
      end else begin
        chk_ack(e[0]);
      end
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  task automatic sb(input logic [7:0] b, input logic a, input logic [8:0] e);
    exp_q.push_back(e);
    mm.byte_io(b, a);
  endtask

  // Random read: address phase, repeated start, one byte, no acknowledge
  task automatic rd(input logic [10:0] ad, input logic [7:0] e);
    mm.start();
    sb({DEV, ad[10:8], 1'b0}, 1'b0, ACK);
    sb(ad[7:0], 1'b0, ACK);
    mm.start();
    sb({DEV, ad[10:8], 1'b1}, 1'b0, ACK);
    sb(8'hFF, 1'b0, {1'b1, e});
    mm.stop();
  endtask

  initial begin
    wp = 1'b0;
    arst_n = 1'b0;
    void'($urandom(98));
    // Upper half, so the protected write later meets stored data
    blk = {1'b1, 2'($urandom)};
    wa = {4'($urandom), 4'hF};
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    repeat (10) @(posedge clk_sys);
    #5 arst_n = 1'b1;
    repeat (5) @(posedge clk_sys);
    // Two bytes from the last place of a page, the second wraps
    mm.start();
    sb({DEV, blk, 1'b0}, 1'b0, ACK);
    sb(wa, 1'b0, ACK);
    sb(d0, 1'b0, ACK);
    sb(d1, 1'b0, ACK);
    mm.stop();
    // Own address during the program cycle is left unanswered
    mm.start();
    sb({DEV, blk, 1'b1}, 1'b0, NAK);
    mm.stop();
    repeat (450) @(posedge clk_sys);
    $display("done: write and lockout");
    rd({blk, wa}, d0);
    rd({blk, wa[7:4], 4'h0}, d1);
    $display("done: read back");
    // Wrong type code, then a protected upper-half write
    mm.start();
    sb({~DEV, blk, 1'b0}, 1'b0, NAK);
    mm.stop();
    @(posedge clk_sys) #5 wp = 1'b1;
    repeat (5) @(posedge clk_sys);
    mm.start();
    sb({DEV, 1'b1, blk[1:0], 1'b0}, 1'b0, ACK);
    sb(wa, 1'b0, ACK);
    sb(~d0, 1'b0, NAK);
    mm.stop();
    // The refused byte must not have replaced the stored one
    rd({blk, wa}, d0);
    $display("done: refusals");
    repeat (20) @(posedge clk_sys);
    summarize();
  end
endmodule // test_serial_eeprom_bus_addressing

`default_nettype wire
